// *** hdl/fcs_consts.vh ***
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
// ****************************************
// timing counts, in mains pulses
// ****************************************
`define FCS_CHARGE_PULSES   655360
`define FCS_DELAY_PULSES    7680
`define FCS_CNT_W           20
// ****************************************
// duty frame of 32 mains pulses
// ****************************************
`define FCS_FRAME_W         5
`define FCS_FULL_SLOTS      28
`define FCS_HALF_SLOTS      14
`define FCS_TRK_FULL_SLOTS  2
`define FCS_TRK_HALF_SLOTS  1
// ****************************************
// fast clock timing at 25 MHz
// ****************************************
`define FCS_CLK_HZ          25000000
`define FCS_GATE_HZ         1500
`define FCS_BLINK_HZ        3
// zero-crossings absent for this many mains pulses means battery present
`define FCS_PRESENT_PULSES  4
`endif

// *** hdl/fcs_sync.v ***
// ****************************************
// two-stage synchroniser for pin inputs
// ****************************************
module fcs_sync #(
    parameter W = 1
) (
    input  wire         mclk_i,
    input  wire         reset_n_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // fcs_sync

// *** hdl/fcs_sequencer.v ***
// How it works
// - mains pulses time delay and charge; the fast clock times gate and blink
// - fast charge ends after 655360 pulses
// - wait 7680 pulses before fast charge
// - no start outside temperature start window
// - stop at maximum temperature immediately
// - stop when battery exceeds ambient offset
// - fast duty 7/8, or 7/16 rate low
// - rate change never disturbs charge timer
// - idle trickle 1/16, or 1/32 rate low
// - hold input forces trickle, timer continues
// - hold released before timeout resumes fast
// - restart falling edge clears timer, restarts
// - zero-crossings mean no battery present
// - selected half-cycles hold the gate high, dropping it for one clock in every 8333
// - indicator on, blink 3 Hz, steady trickle
`include "fcs_consts.vh"
module fcs_sequencer #(
    parameter CHARGE_PULSES = `FCS_CHARGE_PULSES,
    parameter DELAY_PULSES  = `FCS_DELAY_PULSES,
    parameter RESTART_VAR   = 0
) (
    // clock and reset
    input  wire mclk_i,
    input  wire reset_n_i,
    // pins from the charging stage and sense network
    input  wire mains_pulse_i,
    input  wire batt_cross_i,
    input  wire rate_full_i,
    input  wire hold_restart_i,
    // temperature comparators, high when the condition holds
    input  wire temp_above_high_i,
    input  wire temp_below_low_i,
    input  wire temp_at_max_i,
    input  wire temp_delta_i,
    // outputs
    output reg  thyristor_gate_output_o,
    output reg  indicator_output_o,
    output reg  fast_active_o,
    output reg  batt_present_o
);
    localparam GATE_HALF  = `FCS_CLK_HZ / (2 * `FCS_GATE_HZ);
    localparam BLINK_HALF = `FCS_CLK_HZ / (2 * `FCS_BLINK_HZ);
    // 32-bit copies so each compare can take exactly the bits it needs
    localparam [31:0] GATE_LAST   = GATE_HALF - 1;
    localparam [31:0] BLINK_LAST  = BLINK_HALF - 1;
    localparam [31:0] QUIET_LAST  = `FCS_PRESENT_PULSES - 1;
    localparam [31:0] DELAY_LAST  = DELAY_PULSES - 1;
    localparam [31:0] CHARGE_LAST = CHARGE_PULSES - 1;
    localparam [31:0] FULL_SLOTS  = `FCS_FULL_SLOTS;
    localparam [31:0] HALF_SLOTS  = `FCS_HALF_SLOTS;
    localparam [31:0] TRKF_SLOTS  = `FCS_TRK_FULL_SLOTS;
    localparam [31:0] TRKH_SLOTS  = `FCS_TRK_HALF_SLOTS;
    localparam ST_NOBATT  = 3'd0;
    localparam ST_DELAY   = 3'd1;
    localparam ST_WAIT    = 3'd2;
    localparam ST_FAST    = 3'd3;
    localparam ST_DONE    = 3'd4;

    // slot count threshold against slot number in frame
    function slot_on;
        input [4:0] slot;
        input [5:0] nslots;
        begin
            slot_on = ({1'b0, slot} < nslots);
        end
    endfunction

    // ****************************************
    // pin synchronisation
    // ****************************************
    wire [7:0] pins_s;
    fcs_sync #(.W(8)) u_sync (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({mains_pulse_i, batt_cross_i, rate_full_i, hold_restart_i,
                     temp_above_high_i, temp_below_low_i, temp_at_max_i, temp_delta_i}),
        .sync_o    (pins_s)
    );
    wire mains_s = pins_s[7];
    wire cross_s = pins_s[6];
    wire rate_s  = pins_s[5];
    wire hold_s  = pins_s[4];
    wire hi_s    = pins_s[3];
    wire lo_s    = pins_s[2];
    wire max_s   = pins_s[1];
    wire dlt_s   = pins_s[0];

    reg mains_d1_q;
    reg cross_d1_q;
    reg hold_d1_q;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mains_d1_q <= 1'b0;
            cross_d1_q <= 1'b0;
            hold_d1_q  <= 1'b0;
        end else begin
            mains_d1_q <= mains_s;
            cross_d1_q <= cross_s;
            hold_d1_q  <= hold_s;
        end
    end
    wire tick     = mains_s & ~mains_d1_q;
    // frame moves on the falling edge so a slot stays fixed for its whole pulse
    wire mains_fall = ~mains_s & mains_d1_q;
    wire cross_ev = cross_s ^ cross_d1_q;
    wire restart  = (RESTART_VAR != 0) & hold_d1_q & ~hold_s;
    wire hold     = (RESTART_VAR == 0) & hold_s;

    // ****************************************
    // battery presence
    // ****************************************
    reg [2:0] quiet_q;
    reg       present_q;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            quiet_q   <= 3'd0;
            present_q <= 1'b0;
        end else if (cross_ev) begin
            quiet_q   <= 3'd0;
            present_q <= 1'b0;
        end else if (tick) begin
            if (quiet_q == QUIET_LAST[2:0]) begin
                present_q <= 1'b1;
            end else begin
                quiet_q <= quiet_q + 3'd1;
            end
        end
    end

    // ****************************************
    // sequencer and counters
    // ****************************************
    reg [2:0]             state_q;
    reg [`FCS_CNT_W-1:0]  cnt_q;
    reg [4:0]             frame_q;
    wire temp_ok   = ~hi_s & ~lo_s;
    wire temp_stop = max_s | dlt_s;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_NOBATT;
            cnt_q   <= {`FCS_CNT_W{1'b0}};
            frame_q <= 5'd0;
        end else begin
            if (mains_fall) begin
                frame_q <= frame_q + 5'd1;
            end
            if (!present_q) begin
                state_q <= ST_NOBATT;
                cnt_q   <= {`FCS_CNT_W{1'b0}};
            end else begin
                case (state_q)
                    ST_NOBATT: begin
                        state_q <= ST_DELAY;
                        cnt_q   <= {`FCS_CNT_W{1'b0}};
                    end
                    ST_DELAY: begin
                        if (tick) begin
                            if (cnt_q == DELAY_LAST[`FCS_CNT_W-1:0]) begin
                                state_q <= ST_WAIT;
                                cnt_q   <= {`FCS_CNT_W{1'b0}};
                            end else begin
                                cnt_q <= cnt_q + 1'b1;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (temp_ok && !temp_stop) begin
                            state_q <= ST_FAST;
                            cnt_q   <= {`FCS_CNT_W{1'b0}};
                        end
                    end
                    ST_FAST: begin
                        if (restart) begin
                            cnt_q <= {`FCS_CNT_W{1'b0}};
                        end else if (temp_stop) begin
                            state_q <= ST_DONE;
                        end else if (tick) begin
                            // counts even while held in trickle; rate never touches it
                            if (cnt_q == CHARGE_LAST[`FCS_CNT_W-1:0]) begin
                                state_q <= ST_DONE;
                            end else begin
                                cnt_q <= cnt_q + 1'b1;
                            end
                        end
                    end
                    ST_DONE: begin
                        if (restart) begin
                            state_q <= ST_WAIT;
                            cnt_q   <= {`FCS_CNT_W{1'b0}};
                        end
                    end
                    default: begin
                        state_q <= ST_NOBATT;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // duty selection and gate train
    // ****************************************
    wire fast_on = (state_q == ST_FAST) & ~hold;
    reg [5:0] slots;
    always @* begin
        if (fast_on) begin
            slots = rate_s ? FULL_SLOTS[5:0] : HALF_SLOTS[5:0];
        end else if (present_q) begin
            slots = rate_s ? TRKF_SLOTS[5:0] : TRKH_SLOTS[5:0];
        end else begin
            slots = 6'd0;
        end
    end
    wire fire = slot_on(frame_q, slots) & mains_s;

    reg [13:0] gate_cnt_q;
    reg [22:0] blink_cnt_q;
    reg        blink_q;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gate_cnt_q              <= 14'd0;
            blink_cnt_q             <= 23'd0;
            blink_q                 <= 1'b0;
            thyristor_gate_output_o <= 1'b0;
            indicator_output_o      <= 1'b1;
            fast_active_o           <= 1'b0;
            batt_present_o          <= 1'b0;
        end else begin
            // train restarts each half-cycle so every firing starts with a pulse
            if (!fire) begin
                gate_cnt_q              <= 14'd0;
                thyristor_gate_output_o <= 1'b0;
            end else if (gate_cnt_q == GATE_LAST[13:0]) begin
                gate_cnt_q              <= 14'd0;
                thyristor_gate_output_o <= ~thyristor_gate_output_o;
            end else begin
                gate_cnt_q              <= gate_cnt_q + 14'd1;
                if (gate_cnt_q == 14'd0 && !thyristor_gate_output_o) begin
                    thyristor_gate_output_o <= 1'b1;
                end
            end
            if (blink_cnt_q == BLINK_LAST[22:0]) begin
                blink_cnt_q <= 23'd0;
                blink_q     <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 23'd1;
            end
            // a held cycle is trickle, so the indicator goes steady then
            indicator_output_o <= fast_on ? blink_q : 1'b1;
            fast_active_o      <= fast_on;
            batt_present_o     <= present_q;
        end
    end
endmodule // fcs_sequencer

// *** testbench/fcs_sequencer_chk.sv ***
// ****************************************
// port checker
// ****************************************
module fcs_sequencer_chk #(
    parameter RESTART_VAR = 0
) (
    // clock, reset and pins
    input wire mclk_i,
    input wire reset_n_i,
    input wire mains_pulse_i,
    input wire batt_cross_i,
    input wire rate_full_i,
    input wire hold_restart_i,
    input wire temp_above_high_i,
    input wire temp_below_low_i,
    input wire temp_at_max_i,
    input wire temp_delta_i,
    // design outputs
    input wire thyristor_gate_output_o,
    input wire indicator_output_o,
    input wire fast_active_o,
    input wire batt_present_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // five cycles cover two sync flops and the output flop, with a cycle to spare
    sequence s_quiet; !mains_pulse_i [*5]; endsequence
    sequence s_lost; !batt_present_o [*2]; endsequence
    sequence s_bad;
        (!fast_active_o && !hold_restart_i && (temp_above_high_i || temp_below_low_i)) [*6];
    endsequence
    chk_gate_quiet: assert property (s_quiet |-> !thyristor_gate_output_o)
        else $error("gate pulses while mains is low");
    chk_max_stop: assert property (temp_at_max_i [*5] |-> !fast_active_o)
        else $error("fast kept at maximum temperature");
    chk_delta_stop: assert property (temp_delta_i [*5] |-> !fast_active_o)
        else $error("fast kept past ambient offset");
    chk_hold_trickle: assert property ((RESTART_VAR == 0 && hold_restart_i) [*5] |-> !fast_active_o)
        else $error("hold does not force trickle");
    chk_start_window: assert property (s_bad |=> !fast_active_o)
        else $error("fast started outside start window");
    chk_start_delay: assert property ($rose(batt_present_o) |-> !fast_active_o [*8])
        else $error("fast without start delay");
    chk_lost_batt: assert property (s_lost |-> !fast_active_o)
        else $error("fast with no battery");
    chk_ind_nobatt: assert property (s_lost |-> indicator_output_o)
        else $error("indicator off with no battery");
endmodule // fcs_sequencer_chk

bind fcs_sequencer fcs_sequencer_chk #(.RESTART_VAR(RESTART_VAR)) i_fcs_sequencer_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mains_pulse_i(mains_pulse_i),
    .batt_cross_i(batt_cross_i), .rate_full_i(rate_full_i), .hold_restart_i(hold_restart_i),
    .temp_above_high_i(temp_above_high_i), .temp_below_low_i(temp_below_low_i),
    .temp_at_max_i(temp_at_max_i), .temp_delta_i(temp_delta_i),
    .thyristor_gate_output_o(thyristor_gate_output_o), .indicator_output_o(indicator_output_o),
    .fast_active_o(fast_active_o), .batt_present_o(batt_present_o));

// *** testbench/fcs_partner.sv ***
// ****************************************
// mains and battery sense model
// ****************************************
module fcs_partner #(
    parameter int HALF = 60
) (
    // clock and socket state
    input  wire logic mclk_i,
    input  wire logic batt_in_i,
    // sense outputs
    output wire logic mains_pulse_o,
    output wire logic batt_cross_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic tog = 1'b0;
    assign mains_pulse_o = (cnt < HALF);
    // an empty socket passes every mains cycle on as a crossing
    assign batt_cross_o = tog;
    always @(negedge mclk_i) begin
        cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
        if (cnt == 0 && !batt_in_i)
            tog <= ~tog;
    end
endmodule // fcs_partner

// *** testbench/tb_fcs_sequencer.sv ***
// ****************************************
// testbench
// ****************************************
module tb_fcs_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    // short counts keep the run small
    localparam int CHG = 40;
    localparam int DLY = 8;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, batt_in = 1'b0;
    logic        rate_full_i = 1'b1, hold_restart_i = 1'b0;
    logic [3:0]  temp = 4'h0;
    logic [15:0] seed = 16'h7b66;
    wire         mains, xing, gate, ind, fast, pres;
    int          num_errors = 0, n_tests = 0;
    logic        restart_i = 1'b0;
    wire         gate2, fast2;
    int          fires = 0, c0 = 0, fires2 = 0, c2 = 0;
    fcs_sequencer #(.CHARGE_PULSES(CHG), .DELAY_PULSES(DLY), .RESTART_VAR(0)) i_fcs_sequencer (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mains_pulse_i(mains), .batt_cross_i(xing),
        .rate_full_i(rate_full_i), .hold_restart_i(hold_restart_i),
        .temp_above_high_i(temp[3]), .temp_below_low_i(temp[2]), .temp_at_max_i(temp[1]),
        .temp_delta_i(temp[0]), .thyristor_gate_output_o(gate), .indicator_output_o(ind),
        .fast_active_o(fast), .batt_present_o(pres));
    // second copy runs the restart variant on the same sense lines
    fcs_sequencer #(.CHARGE_PULSES(CHG), .DELAY_PULSES(DLY), .RESTART_VAR(1)) i_fcs_sequencer_rst (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mains_pulse_i(mains), .batt_cross_i(xing),
        .rate_full_i(rate_full_i), .hold_restart_i(restart_i),
        .temp_above_high_i(temp[3]), .temp_below_low_i(temp[2]), .temp_at_max_i(temp[1]),
        .temp_delta_i(temp[0]), .thyristor_gate_output_o(gate2), .indicator_output_o(),
        .fast_active_o(fast2), .batt_present_o());
    always @(posedge gate) fires++;
    always @(posedge gate2) fires2++;
    fcs_partner i_fcs_partner (.mclk_i(mclk_i), .batt_in_i(batt_in),
        .mains_pulse_o(mains), .batt_cross_o(xing));
    initial forever #20 mclk_i = ~mclk_i;
    task automatic check(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic pulses(input int n);
        repeat (n) @(posedge mains);
        @(negedge mclk_i);
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic exp_fast(input int elapsed, input logic held);
        return (elapsed < CHG) && !held;
    endfunction
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // presence needs 4 quiet pulses, so the delay has run at most 6 at the check
    task automatic insert(input logic [3:0] t);
        temp = t;
        batt_in = 1'b1;
        pulses(6);
        check(pres, 1'b1);
        pulses(DLY - 4);
        check(ind, 1'b1);
        check(fast, 1'b0);
        pulses(4);
    endtask
    // one gate burst per fired pulse, counted over a whole 32-pulse frame
    task automatic duty(input int exp, input logic rate);
        rate_full_i = rate;
        pulses(1);
        c0 = fires;
        pulses(32);
        check(fires - c0 == exp, 1'b1);
    endtask
    initial begin
        repeat (5) @(negedge mclk_i);
        check(gate, 1'b0);
        reset_n_i = 1'b1;
        pulses(8);
        check(pres, 1'b0);
        check(ind, 1'b1);
        $display("test empty socket done");
        insert(4'h0);
        // the end of the count is skipped where presence timing leaves a pulse of doubt
        for (int p = 3; p < CHG + 5; p++) begin
            seed = lfsr(seed);
            rate_full_i = seed[0];
            hold_restart_i = (p > 9) && (p < 16) && seed[1];
            pulses(1);
            if (p < CHG - 4 || p > CHG + 2)
                check(fast, exp_fast(p, hold_restart_i));
        end
        pulses(DLY + 6);
        check(fast, 1'b0);
        $display("test timed charge done");
        for (int k = 0; k < 2; k++) begin
            batt_in = 1'b0;
            pulses(3);
            check(pres, 1'b0);
            insert(k ? 4'h4 : 4'h8);
            check(fast, 1'b0);
            temp = 4'h0;
            pulses(2);
            check(fast, 1'b1);
            temp = k ? 4'h1 : 4'h2;
            pulses(1);
            check(fast, 1'b0);
            temp = 4'h0;
            pulses(3);
            check(fast, 1'b0);
        end
        $display("test temperature limits done");
        batt_in = 1'b0;
        pulses(3);
        insert(4'h0);
        duty(14, 1'b0);
        pulses(8);
        duty(2, 1'b1);
        check(ind, 1'b1);
        duty(1, 1'b0);
        $display("test duty done");
        restart_i = 1'b1;
        pulses(1);
        restart_i = 1'b0;
        rate_full_i = 1'b1;
        pulses(1);
        c2 = fires2;
        pulses(32);
        check(fires2 - c2 == 28, 1'b1);
        check(fast, 1'b0);
        restart_i = 1'b1;
        pulses(1);
        restart_i = 1'b0;
        pulses(25);
        check(fast2, 1'b1);
        pulses(20);
        check(fast2, 1'b0);
        $display("test restart done");
        give_verdict();
    end
    initial begin
        #(40 * 80000);
        num_errors++;
        give_verdict();
    end
endmodule // tb_fcs_sequencer
